// File: core/arctc_top.sv
// Result counter and threshold counter of the primary ADC channel.
// Assumes the conversion strobe and register port share clk_in; the
// register port never waits and returns read data one cycle later.
`timescale 1ns/100ps
`default_nettype none
module arctc_top
    import arctc_pkg::*;
(
    input  wire logic                      clk_in,    // System clock
    input  wire logic                      resetn_in, // Sync reset, low
    input  wire logic                      ce_in,     // Clock enable
    input  wire arctc_pkg::arctc_bus_req_t bus_in,    // Register request
    input  wire arctc_pkg::arctc_sample_t  sample_in, // Result strobe
    output logic [31:0]                    rd_data_out, // Read data
    output logic                           irq_out      // Interrupt level
);
    import arctc_pkg::*;

    function automatic logic hit(input logic [31:0] a, input logic [31:0] o);
        hit = (a == o);
    endfunction : hit

    logic [15:0] rc_limit;
    logic [15:0] rc_count;
    logic [15:0] thresh;
    logic [7:0]  tc_limit;
    logic [7:0]  tc_count;
    logic [2:0]  config_bits;
    logic        twos;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic [31:0] rd_data;
    logic        irq;

    logic [15:0] next_rc_limit;
    logic [15:0] next_rc_count;
    logic [15:0] next_thresh;
    logic [7:0]  next_tc_limit;
    logic [7:0]  next_tc_count;
    logic [2:0]  next_config_bits;
    logic        next_twos;
    logic [1:0]  next_status;
    logic [1:0]  next_mask;
    logic [31:0] next_rd_data;
    logic        next_irq;

    logic        above;
    logic        wr;
    logic        rd;
    logic        strobe;
    logic [15:0] rc_inc;
    logic        rc_match;
    logic [1:0]  events;

    assign wr     = bus_in.wr;
    assign rd     = bus_in.rd;
    assign strobe = sample_in.valid;

    arctc_mag_cmp #(
        .RES_W           (16)
    ) u_cmp (
        .result_in       (sample_in.value),
        .thresh_in       (thresh),
        .twos_in         (twos),
        .at_or_above_out (above)
    );

    // Register file and configuration
    always_comb begin
        next_rc_limit    = rc_limit;
        next_thresh      = thresh;
        next_tc_limit    = tc_limit;
        next_config_bits = config_bits;
        next_twos        = twos;
        next_mask        = mask;
        if (wr) begin
            if (hit(bus_in.addr, ARCTC_OFF_RCLIMIT)) begin
                next_rc_limit = bus_in.wdata[15:0];
            end
            if (hit(bus_in.addr, ARCTC_OFF_THRESH)) begin
                next_thresh = bus_in.wdata[15:0];
            end
            if (hit(bus_in.addr, ARCTC_OFF_TCLIMIT)) begin
                next_tc_limit = bus_in.wdata[ARCTC_TC_LIM_W-1:0];
            end
            if (hit(bus_in.addr, ARCTC_OFF_CONFIG)) begin
                next_config_bits = bus_in.wdata[2:0];
            end
            if (hit(bus_in.addr, ARCTC_OFF_CONTROL)) begin
                next_twos = bus_in.wdata[ARCTC_CTL_TWOS];
            end
            if (hit(bus_in.addr, ARCTC_OFF_MASK)) begin
                next_mask = bus_in.wdata[1:0];
            end
        end
    end

    // Result counter
    always_comb begin
        rc_inc        = 16'(rc_count + 16'h0001);
        rc_match      = 1'b0;
        next_rc_count = rc_count;
        if (strobe && config_bits[ARCTC_CFG_RC_EN]) begin
            if (rc_inc == rc_limit) begin
                next_rc_count = ARCTC_RST_RCOUNT;
                rc_match      = 1'b1;
            end else begin
                next_rc_count = rc_inc;
            end
        end
        if (wr && (hit(bus_in.addr, ARCTC_OFF_CONTROL) ||
                   hit(bus_in.addr, ARCTC_OFF_MODE))) begin
            next_rc_count = ARCTC_RST_RCOUNT;
        end
    end

    // Threshold counter
    always_comb begin
        next_tc_count = tc_count;
        if (strobe && config_bits[ARCTC_CFG_TC_EN]) begin
            if (above) begin
                if (tc_count != 8'hff) begin
                    next_tc_count = 8'(tc_count + 8'h01);
                end
            end else if (config_bits[ARCTC_CFG_TC_DEC]) begin
                if (tc_count != 8'h00) begin
                    next_tc_count = 8'(tc_count - 8'h01);
                end
            end else begin
                next_tc_count = ARCTC_RST_TCOUNT;
            end
        end
    end

    // Sticky status, set wins over a write-one clear
    always_comb begin
        events = 2'h0;
        if (strobe) begin
            events[ARCTC_ST_READY] = config_bits[ARCTC_CFG_RC_EN] ?
                                     rc_match : 1'b1;
        end
        if (strobe && config_bits[ARCTC_CFG_TC_EN] &&
            (next_tc_count == tc_limit)) begin
            events[ARCTC_ST_THRESH] = 1'b1;
        end
        next_status = status;
        if (wr && hit(bus_in.addr, ARCTC_OFF_STATUS)) begin
            next_status = status & ~bus_in.wdata[1:0];
        end
        next_status = next_status | events;
        next_irq    = |(next_status & next_mask);
    end

    // Read data, valid only in the cycle after the read strobe
    always_comb begin
        next_rd_data = 32'h0000_0000;
        if (rd) begin
            case (bus_in.addr)
                ARCTC_OFF_RCLIMIT: next_rd_data = {16'h0000, rc_limit};
                ARCTC_OFF_RCOUNT:  next_rd_data = {16'h0000, rc_count};
                ARCTC_OFF_THRESH:  next_rd_data = {16'h0000, thresh};
                ARCTC_OFF_TCLIMIT: next_rd_data = {24'h000000, tc_limit};
                ARCTC_OFF_TCOUNT:  next_rd_data = {24'h000000, tc_count};
                ARCTC_OFF_CONFIG:  next_rd_data = {29'h0, config_bits};
                ARCTC_OFF_CONTROL: next_rd_data = {31'h0, twos};
                ARCTC_OFF_STATUS:  next_rd_data = {30'h0, status};
                ARCTC_OFF_MASK:    next_rd_data = {30'h0, mask};
                default:           next_rd_data = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            rc_limit    <= ARCTC_RST_RCLIMIT;
            rc_count    <= ARCTC_RST_RCOUNT;
            thresh      <= ARCTC_RST_THRESH;
            tc_limit    <= ARCTC_RST_TCLIMIT;
            tc_count    <= ARCTC_RST_TCOUNT;
            config_bits <= ARCTC_RST_CONFIG;
            twos        <= 1'b0;
            status      <= ARCTC_RST_STATUS;
            mask        <= ARCTC_RST_MASK;
            rd_data     <= 32'h0000_0000;
            irq         <= 1'b0;
        end else if (ce_in) begin
            rc_limit    <= next_rc_limit;
            rc_count    <= next_rc_count;
            thresh      <= next_thresh;
            tc_limit    <= next_tc_limit;
            tc_count    <= next_tc_count;
            config_bits <= next_config_bits;
            twos        <= next_twos;
            status      <= next_status;
            mask        <= next_mask;
            rd_data     <= next_rd_data;
            irq         <= next_irq;
        end
    end

    assign rd_data_out = rd_data;
    assign irq_out     = irq;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    rc_counts_a: assert property (
        (ce_in && strobe && config_bits[ARCTC_CFG_RC_EN] && !wr &&
         rc_inc != rc_limit) |=> (rc_count == $past(rc_count) + 16'h0001))
        else $error("result count did not advance");

    rc_frozen_a: assert property (
        (ce_in && !config_bits[ARCTC_CFG_RC_EN] && !wr)
        |=> $stable(rc_count))
        else $error("result count moved while disabled");

    rc_wrap_a: assert property (
        (ce_in && strobe && config_bits[ARCTC_CFG_RC_EN] &&
         rc_inc == rc_limit) |=> (rc_count == 16'h0000) &&
        status[ARCTC_ST_READY])
        else $error("result count did not wrap at limit");

    rdy_gated_a: assert property (
        (ce_in && strobe && config_bits[ARCTC_CFG_RC_EN] &&
         rc_inc != rc_limit && !status[ARCTC_ST_READY] &&
         !(wr && hit(bus_in.addr, ARCTC_OFF_STATUS)))
        |=> !status[ARCTC_ST_READY])
        else $error("result flag set without count match");

    rc_reconf_a: assert property (
        (ce_in && wr && (hit(bus_in.addr, ARCTC_OFF_CONTROL) ||
         hit(bus_in.addr, ARCTC_OFF_MODE))) |=> (rc_count == 16'h0000))
        else $error("reconfiguration did not clear count");

    tc_clear_a: assert property (
        (ce_in && strobe && config_bits == 3'h2 && !above)
        |=> (tc_count == 8'h00))
        else $error("threshold count not cleared below threshold");

    tc_up_a: assert property (
        (ce_in && strobe && config_bits[ARCTC_CFG_TC_EN] && above &&
         tc_count != 8'hff) |=> (tc_count == $past(tc_count) + 8'h01))
        else $error("threshold count did not rise");

    th_flag_a: assert property (
        (ce_in && strobe && config_bits[ARCTC_CFG_TC_EN] &&
         next_tc_count == tc_limit) |=> status[ARCTC_ST_THRESH])
        else $error("threshold flag missing at limit");

    irq_level_a: assert property (
        ce_in |=> (irq_out == |(status & mask)))
        else $error("interrupt does not follow status and mask");

    rd_lim_a: assert property (
        (ce_in && rd && bus_in.addr == ARCTC_OFF_TCLIMIT)
        |=> (rd_data_out[31:8] == 24'h000000))
        else $error("reserved limit bits read nonzero");

    wrap_cov_c: cover property (
        ce_in && strobe && rc_match);
    th_hit_cov_c: cover property (
        ce_in && events[ARCTC_ST_THRESH]);
    irq_cov_c: cover property (
        !irq_out ##1 irq_out);
    clr_race_cov_c: cover property (
        ce_in && wr && hit(bus_in.addr, ARCTC_OFF_STATUS) && |events);

endmodule : arctc_top
`default_nettype wire

// File: shared/arctc_pkg.sv
// Package of the ADC result and threshold counter block.
// Assumes one 100 MHz system clock and byte addresses on the register port.
package arctc_pkg;

    // Register byte addresses
    localparam logic [31:0] ARCTC_OFF_RCLIMIT   = 32'hffff0534;
    localparam logic [31:0] ARCTC_OFF_RCOUNT    = 32'hffff0538;
    localparam logic [31:0] ARCTC_OFF_THRESH    = 32'hffff053c;
    localparam logic [31:0] ARCTC_OFF_TCLIMIT   = 32'hffff0540;
    localparam logic [31:0] ARCTC_OFF_TCOUNT    = 32'hffff0544;
    localparam logic [31:0] ARCTC_OFF_CONFIG    = 32'hffff0580;
    localparam logic [31:0] ARCTC_OFF_CONTROL   = 32'hffff0584;
    localparam logic [31:0] ARCTC_OFF_MODE      = 32'hffff0588;
    localparam logic [31:0] ARCTC_OFF_STATUS    = 32'hffff058c;
    localparam logic [31:0] ARCTC_OFF_MASK      = 32'hffff0590;

    // Reset values
    localparam logic [15:0] ARCTC_RST_RCLIMIT   = 16'h0001;
    localparam logic [15:0] ARCTC_RST_RCOUNT    = 16'h0000;
    localparam logic [15:0] ARCTC_RST_THRESH    = 16'h0000;
    localparam logic [7:0]  ARCTC_RST_TCLIMIT   = 8'h01;
    localparam logic [7:0]  ARCTC_RST_TCOUNT    = 8'h00;
    localparam logic [2:0]  ARCTC_RST_CONFIG    = 3'h0;
    localparam logic [1:0]  ARCTC_RST_STATUS    = 2'h0;
    localparam logic [1:0]  ARCTC_RST_MASK      = 2'h0;

    // Field positions
    localparam int ARCTC_CFG_RC_EN   = 0;  // Result counter enable
    localparam int ARCTC_CFG_TC_EN   = 1;  // Threshold counter enable
    localparam int ARCTC_CFG_TC_DEC  = 2;  // Below threshold: 1 decrement
    localparam int ARCTC_CTL_TWOS    = 0;  // Twos complement coding
    localparam int ARCTC_ST_READY    = 0;  // Result interrupt flag
    localparam int ARCTC_ST_THRESH   = 1;  // Threshold count at limit flag
    localparam int ARCTC_TC_LIM_W    = 8;  // Used bits of limit register

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } arctc_bus_req_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] value;
    } arctc_sample_t;

endpackage : arctc_pkg

// File: core/arctc_mag_cmp.sv
// Magnitude comparator of a conversion result against the threshold.
// Assumes the result and threshold come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module arctc_mag_cmp #(
    parameter int RES_W = 16
) (
    input  wire logic [RES_W-1:0] result_in,     // Conversion result
    input  wire logic [RES_W-1:0] thresh_in,     // Threshold value
    input  wire logic             twos_in,       // Twos complement coding
    output logic                  at_or_above_out // Magnitude >= threshold
);
    logic [RES_W-1:0] magnitude;
    logic [RES_W-1:0] thresh_used;

    generate
        if (RES_W < 2) begin : g_bad_width
            $error("arctc_mag_cmp needs RES_W of at least 2");
        end
    endgenerate

    always_comb begin
        magnitude   = result_in;
        thresh_used = thresh_in;
        if (twos_in) begin
            thresh_used = {1'b0, thresh_in[RES_W-2:0]};
            if (result_in[RES_W-1]) begin
                magnitude = RES_W'(~result_in + 1'b1);
            end
            // Most negative code saturates to the largest magnitude
            if (magnitude[RES_W-1]) begin
                magnitude = {1'b0, {(RES_W-1){1'b1}}};
            end
        end
        at_or_above_out = (magnitude >= thresh_used);
    end
endmodule : arctc_mag_cmp
`default_nettype wire

// File: sim/arctc_top_tb.sv
// Self-checking bench of the ADC result and threshold counter block.
// Assumes read data appear in the cycle after the read strobe only.
`timescale 1ns/100ps
`default_nettype none
module arctc_top_tb;
    import arctc_pkg::*;
    logic           clk_in;
    logic           resetn_in;
    logic           ce_in;
    arctc_bus_req_t bus_in;
    arctc_sample_t  sample_in;
    logic [31:0]    rd_data_out;
    logic           irq_out;
    logic           rd_q;
    logic [31:0]    exp_q[$];
    logic [31:0]    rng;
    int             error_cnt;
    int             check_count;

    arctc_top u_dut (
        .clk_in      (clk_in),
        .resetn_in   (resetn_in),
        .ce_in       (ce_in),
        .bus_in      (bus_in),
        .sample_in   (sample_in),
        .rd_data_out (rd_data_out),
        .irq_out     (irq_out)
    );

    initial clk_in = 1'b0;
    always #5 clk_in = ~clk_in;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim;
        if (exp_q.size() != 0) begin
            error_cnt++;
            $display("[FAIL] %0t reads left unanswered", $time);
        end
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs

    // One bus cycle, then the port goes idle for one cycle
    task automatic acc(input logic [31:0] a, input logic [31:0] d,
                       input logic w);
        @(posedge clk_in);
        bus_in <= '{addr: a, wdata: d, wr: w, rd: ~w};
        @(posedge clk_in);
        bus_in <= '{default: '0};
    endtask : acc

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        acc(a, d, 1'b1);
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        acc(a, 32'h0, 1'b0);
    endtask : rd

    // Back-to-back result strobes, fixed or random values
    task automatic strobe(input int n, input logic [15:0] v,
                          input logic rnd);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_in);
            rng = xs(rng);
            sample_in <= '{valid: 1'b1, value: rnd ? rng[15:0] : v};
        end
        @(posedge clk_in);
        sample_in <= '{valid: 1'b0, value: rng[31:16]};
    endtask : strobe

    task automatic irq_is(input logic e);
        repeat (2) @(posedge clk_in);
        #1;
        check({31'h0, irq_out}, {31'h0, e});
    endtask : irq_is

    // Monitor: each read answer is matched with the oldest note
    always @(posedge clk_in) rd_q <= bus_in.rd & ce_in & resetn_in;
    always @(negedge clk_in) begin
        if (rd_q === 1'b1) begin
            if (exp_q.size() == 0) begin
                error_cnt++;
                $display("[FAIL] %0t read answer with no note", $time);
            end else begin
                check(rd_data_out, exp_q.pop_front());
            end
        end
    end

    initial begin
        repeat (5000) @(posedge clk_in);
        error_cnt++;
        $display("[FAIL] %0t run did not finish in time", $time);
        end_sim();
    end

    initial begin
        rng = 32'd48827;
        error_cnt = 0;
        check_count = 0;
        rd_q = 1'b0;
        resetn_in = 1'b0;
        ce_in = 1'b1;
        bus_in = '{default: '0};
        sample_in = '{default: '0};
        repeat (2) @(posedge clk_in);
        resetn_in <= 1'b1;
        rd(ARCTC_OFF_RCLIMIT, 32'h1);
        rd(ARCTC_OFF_RCOUNT, 32'h0);
        rd(ARCTC_OFF_THRESH, 32'h0);
        rd(ARCTC_OFF_TCLIMIT, 32'h1);
        rd(ARCTC_OFF_TCOUNT, 32'h0);
        rd(32'hffff05f0, 32'h0);
        wr(ARCTC_OFF_TCLIMIT, 32'h0000abcd);
        rd(ARCTC_OFF_TCLIMIT, 32'h000000cd);
        wr(ARCTC_OFF_THRESH, 32'h0000beef);
        rd(ARCTC_OFF_THRESH, 32'h0000beef);
        wr(ARCTC_OFF_RCLIMIT, 32'h0000fffe);
        rd(ARCTC_OFF_RCLIMIT, 32'h0000fffe);
        // Counter off: no counting, every result flags
        strobe(3, 16'h0, 1'b1);
        rd(ARCTC_OFF_RCOUNT, 32'h0);
        rd(ARCTC_OFF_STATUS, 32'h1);
        wr(ARCTC_OFF_STATUS, 32'h1);
        rd(ARCTC_OFF_STATUS, 32'h0);
        // Counter on, limit three, read-only count ignores writes
        wr(ARCTC_OFF_CONFIG, 32'h1);
        wr(ARCTC_OFF_RCLIMIT, 32'h3);
        wr(ARCTC_OFF_MASK, 32'h1);
        wr(ARCTC_OFF_RCOUNT, 32'h1234);
        strobe(2, 16'h0, 1'b1);
        rd(ARCTC_OFF_RCOUNT, 32'h2);
        rd(ARCTC_OFF_STATUS, 32'h0);
        irq_is(1'b0);
        @(posedge clk_in);
        ce_in <= 1'b0;
        strobe(1, 16'h0, 1'b1);
        ce_in <= 1'b1;
        rd(ARCTC_OFF_RCOUNT, 32'h2);
        strobe(1, 16'h0, 1'b1);
        rd(ARCTC_OFF_RCOUNT, 32'h0);
        rd(ARCTC_OFF_STATUS, 32'h1);
        irq_is(1'b1);
        wr(ARCTC_OFF_STATUS, 32'h1);
        irq_is(1'b0);
        strobe(3, 16'h0, 1'b1);
        rd(ARCTC_OFF_RCOUNT, 32'h0);
        rd(ARCTC_OFF_STATUS, 32'h1);
        wr(ARCTC_OFF_STATUS, 32'h1);
        // Writing control or mode restarts the count
        strobe(2, 16'h0, 1'b1);
        wr(ARCTC_OFF_CONTROL, 32'h0);
        rd(ARCTC_OFF_RCOUNT, 32'h0);
        strobe(1, 16'h0, 1'b1);
        rd(ARCTC_OFF_RCOUNT, 32'h1);
        wr(ARCTC_OFF_MODE, 32'h0);
        rd(ARCTC_OFF_RCOUNT, 32'h0);
        // Threshold counter, clear on below
        wr(ARCTC_OFF_CONFIG, 32'h2);
        wr(ARCTC_OFF_THRESH, 32'h0100);
        wr(ARCTC_OFF_TCLIMIT, 32'h3);
        wr(ARCTC_OFF_MASK, 32'h2);
        wr(ARCTC_OFF_STATUS, 32'h3);
        strobe(1, 16'h0100, 1'b0);
        rd(ARCTC_OFF_TCOUNT, 32'h1);
        strobe(1, 16'h00ff, 1'b0);
        rd(ARCTC_OFF_TCOUNT, 32'h0);
        strobe(2, 16'h0200, 1'b0);
        rd(ARCTC_OFF_STATUS, 32'h1);
        irq_is(1'b0);
        strobe(1, 16'hf000, 1'b0);
        rd(ARCTC_OFF_TCOUNT, 32'h3);
        rd(ARCTC_OFF_STATUS, 32'h3);
        irq_is(1'b1);
        wr(ARCTC_OFF_STATUS, 32'h2);
        irq_is(1'b0);
        // Decrement on below, then both codings
        wr(ARCTC_OFF_CONFIG, 32'h6);
        strobe(1, 16'h0000, 1'b0);
        rd(ARCTC_OFF_TCOUNT, 32'h2);
        wr(ARCTC_OFF_THRESH, 32'h8100);
        strobe(1, 16'h0200, 1'b0);
        rd(ARCTC_OFF_TCOUNT, 32'h1);
        wr(ARCTC_OFF_CONTROL, 32'h1);
        strobe(1, 16'hff00, 1'b0);
        rd(ARCTC_OFF_TCOUNT, 32'h2);
        strobe(1, 16'hff01, 1'b0);
        rd(ARCTC_OFF_TCOUNT, 32'h1);
        strobe(2, 16'h8000, 1'b0);
        rd(ARCTC_OFF_STATUS, 32'h3);
        rd(ARCTC_OFF_CONFIG, 32'h6);
        rd(ARCTC_OFF_CONTROL, 32'h1);
        rd(ARCTC_OFF_MASK, 32'h2);
        rd(ARCTC_OFF_MODE, 32'h0);
        irq_is(1'b1);
        end_sim();
    end
endmodule : arctc_top_tb
`default_nettype wire
